// File: acc_pkg.sv
// Package of constants for the analog comparator control block
package acc_pkg;

	localparam logic [11:0] ACC_STATUS_CONTROL_OFS = 12'h000;
	localparam logic [11:0] ACC_IRQ_STATUS_OFS     = 12'h004;
	localparam logic [11:0] ACC_IRQ_MASK_OFS       = 12'h008;
	localparam logic [11:0] ACC_POWER_MODE_OFS     = 12'h00c;
	localparam logic [11:0] ACC_SYSTEM_OPTIONS_OFS = 12'h010;

	localparam int          ACC_ENABLE_BIT      = 7;
	localparam int          ACC_REF_SEL_BIT     = 6;
	localparam int          ACC_FLAG_BIT        = 5;
	localparam int          ACC_IRQ_EN_BIT      = 4;
	localparam int          ACC_OUT_VALUE_BIT   = 3;
	localparam int          ACC_PIN_EN_BIT      = 2;
	localparam int          ACC_EDGE_SEL_HI     = 1;
	localparam int          ACC_EDGE_SEL_LO     = 0;
	localparam int          ACC_ROUTE_BIT       = 0;

	localparam logic [7:0]  ACC_CTRL_RESET      = 8'h00;
	localparam logic [7:0]  ACC_CTRL_WR_MASK    = 8'hd7;
	localparam logic [1:0]  ACC_IRQ_RESET       = 2'h0;
	localparam logic [1:0]  ACC_ROUTE_RESET     = 2'h0;

	// Bit positions in the sticky status and mask registers
	localparam int          ACC_EV_COMPARE      = 0;
	localparam int          ACC_EV_STOP_WAKE    = 1;
	localparam int          ACC_NUM_EVENTS      = 2;

	localparam int          ACC_SYNC_STAGES     = 2;

	typedef enum logic [1:0] {
		ACC_EDGE_FALL_A = 2'b00,
		ACC_EDGE_RISE   = 2'b01,
		ACC_EDGE_FALL_B = 2'b10,
		ACC_EDGE_BOTH   = 2'b11
	} acc_edge_e;

	typedef enum logic [1:0] {
		ACC_PM_RUN        = 2'b00,
		ACC_PM_WAIT       = 2'b01,
		ACC_PM_LIGHT_STOP = 2'b10,
		ACC_PM_DEEP_STOP  = 2'b11
	} acc_pm_e;

endpackage

// File: acc_sync.sv
// Two-flop level synchroniser with edge outputs
`timescale 1ns/1ns
module acc_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clr,
	input  wire logic async_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	import acc_pkg::*;

	logic [ACC_SYNC_STAGES-1:0] sync_q;
	logic                       prev_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q <= '0;
		end else if (clr) begin
			sync_q <= '0;
		end else begin
			sync_q <= {sync_q[ACC_SYNC_STAGES-2:0], async_in};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 1'b0;
		end else if (clr) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= sync_q[ACC_SYNC_STAGES-1];
		end
	end

	assign level = sync_q[ACC_SYNC_STAGES-1];
	assign rise  = sync_q[ACC_SYNC_STAGES-1] & ~prev_q;
	assign fall  = ~sync_q[ACC_SYNC_STAGES-1] & prev_q;

endmodule

// File: acc_top.sv
// Analog comparator control and status logic with APB register access
`timescale 1ns/1ns
module acc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        comparator_raw_out,
	input  wire logic        debug_active,
	output logic             analog_enable,
	output logic             reference_input_select,
	output logic             comparator_output_pin,
	output logic             comparator_output_pin_oe,
	output logic             timer_capture_in,
	output logic             timer_channel_zero_pin_block,
	output logic             irq
);
	import acc_pkg::*;

	// Control and status register
	logic       comparator_enable_q;
	logic       reference_select_q;
	logic       compare_event_flag_q;
	logic       compare_irq_enable_q;
	logic       output_pin_enable_q;
	logic [1:0] event_edge_select_q;

	// Power mode, capture routing, interrupt wrapper
	logic [1:0]                power_mode_q;
	logic                      capture_route_select_q;
	logic [ACC_NUM_EVENTS-1:0] irq_status_q;
	logic [ACC_NUM_EVENTS-1:0] irq_status_d;
	logic [ACC_NUM_EVENTS-1:0] irq_mask_q;
	logic [ACC_NUM_EVENTS-1:0] irq_event;
	logic [31:0]               prdata_q;

	logic       wr_access;
	logic       rd_access;
	logic       addr_hit;
	logic       in_stop;
	logic       in_light_stop;
	logic       in_deep_stop;
	logic       active;
	logic       deep_stop_q;
	logic       out_level;
	logic       out_rise;
	logic       out_fall;
	logic       compare_event;
	logic       flag_clear;
	logic [7:0] ctrl_view;
	logic       ctrl_wr;
	logic       pm_wr;
	logic       status_wr;
	logic       mask_wr;
	logic       route_wr;
	logic       sync_clr;

	function automatic logic acc_edge_hit(input logic [1:0] sel, input logic r, input logic f);
		case (sel)
			ACC_EDGE_FALL_A: acc_edge_hit = f;
			ACC_EDGE_RISE:   acc_edge_hit = r;
			ACC_EDGE_FALL_B: acc_edge_hit = f;
			ACC_EDGE_BOTH:   acc_edge_hit = r | f;
			default:         acc_edge_hit = 1'b0;
		endcase
	endfunction

	function automatic logic acc_reg_hit(input logic [11:0] a, input logic [11:0] ofs);
		acc_reg_hit = (a == ofs);
	endfunction

	assign wr_access = psel & penable & pwrite;
	assign rd_access = psel & penable & ~pwrite;
	assign addr_hit  = acc_reg_hit(paddr, ACC_STATUS_CONTROL_OFS) | acc_reg_hit(paddr, ACC_IRQ_STATUS_OFS) |
		acc_reg_hit(paddr, ACC_IRQ_MASK_OFS) | acc_reg_hit(paddr, ACC_POWER_MODE_OFS) |
		acc_reg_hit(paddr, ACC_SYSTEM_OPTIONS_OFS);

	assign ctrl_wr   = wr_access & pstrb[0] & acc_reg_hit(paddr, ACC_STATUS_CONTROL_OFS);
	assign status_wr = wr_access & pstrb[0] & acc_reg_hit(paddr, ACC_IRQ_STATUS_OFS);
	assign mask_wr   = wr_access & pstrb[0] & acc_reg_hit(paddr, ACC_IRQ_MASK_OFS);
	assign pm_wr     = wr_access & pstrb[0] & acc_reg_hit(paddr, ACC_POWER_MODE_OFS);
	assign route_wr  = wr_access & pstrb[0] & acc_reg_hit(paddr, ACC_SYSTEM_OPTIONS_OFS);

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;

	// Power mode decode; debug halt is run mode for this block
	assign in_light_stop = (power_mode_q == ACC_PM_LIGHT_STOP);
	assign in_deep_stop  = (power_mode_q == ACC_PM_DEEP_STOP);
	assign in_stop       = in_light_stop | in_deep_stop;
	assign active        = comparator_enable_q & ~in_stop;

	assign analog_enable          = active;
	assign reference_input_select = reference_select_q;
	assign sync_clr               = ~active;

	// Comparator result is high when the positive input is above the negative one
	acc_sync u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.clr      (sync_clr),
		.async_in (comparator_raw_out),
		.level    (out_level),
		.rise     (out_rise),
		.fall     (out_fall)
	);

	assign compare_event = active & acc_edge_hit(event_edge_select_q, out_rise, out_fall);
	assign flag_clear    = ctrl_wr & pwdata[ACC_FLAG_BIT];

	// Deep stop behaves as a power-down reset of the whole control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deep_stop_q <= 1'b0;
		end else begin
			deep_stop_q <= in_deep_stop;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comparator_enable_q <= ACC_CTRL_RESET[ACC_ENABLE_BIT];
		end else if (in_deep_stop) begin
			comparator_enable_q <= ACC_CTRL_RESET[ACC_ENABLE_BIT];
		end else if (ctrl_wr & ~in_light_stop) begin
			comparator_enable_q <= pwdata[ACC_ENABLE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reference_select_q <= ACC_CTRL_RESET[ACC_REF_SEL_BIT];
		end else if (in_deep_stop) begin
			reference_select_q <= ACC_CTRL_RESET[ACC_REF_SEL_BIT];
		end else if (ctrl_wr & ~in_light_stop) begin
			reference_select_q <= pwdata[ACC_REF_SEL_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_irq_enable_q <= ACC_CTRL_RESET[ACC_IRQ_EN_BIT];
		end else if (in_deep_stop) begin
			compare_irq_enable_q <= ACC_CTRL_RESET[ACC_IRQ_EN_BIT];
		end else if (ctrl_wr & ~in_light_stop) begin
			compare_irq_enable_q <= pwdata[ACC_IRQ_EN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_pin_enable_q <= ACC_CTRL_RESET[ACC_PIN_EN_BIT];
		end else if (in_deep_stop) begin
			output_pin_enable_q <= ACC_CTRL_RESET[ACC_PIN_EN_BIT];
		end else if (ctrl_wr & ~in_light_stop) begin
			output_pin_enable_q <= pwdata[ACC_PIN_EN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_edge_select_q <= ACC_CTRL_RESET[ACC_EDGE_SEL_HI:ACC_EDGE_SEL_LO];
		end else if (in_deep_stop) begin
			event_edge_select_q <= ACC_CTRL_RESET[ACC_EDGE_SEL_HI:ACC_EDGE_SEL_LO];
		end else if (ctrl_wr & ~in_light_stop) begin
			event_edge_select_q <= pwdata[ACC_EDGE_SEL_HI:ACC_EDGE_SEL_LO];
		end
	end

	// Flag: event wins over a same-cycle clear, a written zero is ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_event_flag_q <= ACC_CTRL_RESET[ACC_FLAG_BIT];
		end else if (in_deep_stop) begin
			compare_event_flag_q <= ACC_CTRL_RESET[ACC_FLAG_BIT];
		end else if (compare_event) begin
			compare_event_flag_q <= 1'b1;
		end else if (flag_clear & ~in_light_stop) begin
			compare_event_flag_q <= 1'b0;
		end
	end

	// Power mode is driven by the system's low-power controller over the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_mode_q <= ACC_PM_RUN;
		end else if (pm_wr) begin
			power_mode_q <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_route_select_q <= ACC_ROUTE_RESET[0];
		end else if (route_wr) begin
			capture_route_select_q <= pwdata[ACC_ROUTE_BIT];
		end
	end

	// Wrapper events: the compare event and the return from deep stop
	assign irq_event[ACC_EV_COMPARE]   = compare_event;
	assign irq_event[ACC_EV_STOP_WAKE] = deep_stop_q & ~in_deep_stop;

	generate
		for (genvar i = 0; i < ACC_NUM_EVENTS; i++) begin : g_irq
			always_comb begin
				irq_status_d[i] = irq_status_q[i];
				if (status_wr & pwdata[i]) begin
					irq_status_d[i] = 1'b0;
				end
				if (irq_event[i]) begin
					irq_status_d[i] = 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_q <= ACC_IRQ_RESET;
		end else begin
			irq_status_q <= irq_status_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= ACC_IRQ_RESET;
		end else if (mask_wr) begin
			irq_mask_q <= pwdata[ACC_NUM_EVENTS-1:0];
		end
	end

	// Request follows the flag itself so the flag clear removes it
	assign irq = (compare_irq_enable_q & compare_event_flag_q & irq_mask_q[ACC_EV_COMPARE]) |
		(irq_status_q[ACC_EV_STOP_WAKE] & irq_mask_q[ACC_EV_STOP_WAKE]);

	assign ctrl_view = {comparator_enable_q, reference_select_q, compare_event_flag_q, compare_irq_enable_q,
		out_level & active, output_pin_enable_q, event_edge_select_q};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			case (paddr)
				ACC_STATUS_CONTROL_OFS: prdata_q <= {24'h00_0000, ctrl_view};
				ACC_IRQ_STATUS_OFS:     prdata_q <= {30'h0000_0000, irq_status_q};
				ACC_IRQ_MASK_OFS:       prdata_q <= {30'h0000_0000, irq_mask_q};
				ACC_POWER_MODE_OFS:     prdata_q <= {30'h0000_0000, power_mode_q};
				ACC_SYSTEM_OPTIONS_OFS: prdata_q <= {31'h0000_0000, capture_route_select_q};
				default:                prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Control register reads live; the others come from the setup-phase sample
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_access) begin
			if (acc_reg_hit(paddr, ACC_STATUS_CONTROL_OFS)) begin
				prdata = {24'h00_0000, ctrl_view};
			end else begin
				prdata = prdata_q;
			end
		end
	end

	// Output pin and timer routing
	assign comparator_output_pin        = out_level & active & output_pin_enable_q;
	assign comparator_output_pin_oe     = output_pin_enable_q & active;
	assign timer_capture_in             = capture_route_select_q & out_level & active;
	assign timer_channel_zero_pin_block = capture_route_select_q;

endmodule

// File: acc_analog_model.sv
// Behavioural model of the analog inputs that feed the comparator
`timescale 1ns/1ns
module acc_analog_model #(
	parameter int BANDGAP_MV = 1200
) (
	input  wire logic        analog_enable,
	input  wire logic        reference_input_select,
	input  wire logic        bandgap_buffer_enable,
	input  wire logic [11:0] pos_mv,
	input  wire logic [11:0] neg_mv,
	output logic             comparator_raw_out
);
	logic [11:0] noninv_mv;
	// Without its buffer the reference node sits at ground
	assign noninv_mv = reference_input_select ? (bandgap_buffer_enable ? 12'(BANDGAP_MV) : 12'h000) : pos_mv;
	// A powered-down comparator holds its output low
	assign comparator_raw_out = analog_enable && (noninv_mv > neg_mv);
endmodule

// File: acc_top_props.sv
// Port-level assertions for the comparator control block
`timescale 1ns/1ns
module acc_top_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        comparator_raw_out,
	input wire logic        analog_enable,
	input wire logic        comparator_output_pin,
	input wire logic        comparator_output_pin_oe,
	input wire logic        timer_capture_in,
	input wire logic        timer_channel_zero_pin_block
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	oe_needs_enable_a: assert property (comparator_output_pin_oe |-> analog_enable)
		else $error("pin driven while comparator off");
	idle_outputs_a: assert property (!analog_enable |-> !timer_capture_in && !comparator_output_pin_oe)
		else $error("outputs active while comparator off");
	capture_blocks_pin_a: assert property (timer_capture_in |-> timer_channel_zero_pin_block)
		else $error("capture fed while channel pin free");
	pin_follows_a: assert property ((comparator_output_pin_oe && $stable(comparator_raw_out))[*3] |->
		comparator_output_pin == comparator_raw_out) else $error("pin does not follow comparator");
	capture_follows_a: assert property ((timer_channel_zero_pin_block && analog_enable && $stable(comparator_raw_out))[*3]
		|-> timer_capture_in == comparator_raw_out) else $error("capture does not follow comparator");
	output_bit_zero_a: assert property (psel && penable && paddr == 12'h000 && !analog_enable |-> !prdata[3])
		else $error("output bit set while comparator off");
	unmapped_error_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	zero_wait_a: assert property (psel && !penable |=> pready)
		else $error("access phase not ready");
endmodule

bind acc_top acc_top_checker u_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
	.comparator_raw_out, .analog_enable, .comparator_output_pin, .comparator_output_pin_oe, .timer_capture_in,
	.timer_channel_zero_pin_block);

// File: testbench.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq, debug_active, bg_buf_en;
	logic        comparator_raw_out, analog_enable, reference_input_select, comparator_output_pin;
	logic        comparator_output_pin_oe, timer_capture_in, timer_channel_zero_pin_block;
	logic [11:0] paddr, pos_mv, neg_mv;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	int          n_mismatch, comparisons;

	acc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.comparator_raw_out, .debug_active, .analog_enable, .reference_input_select, .comparator_output_pin,
		.comparator_output_pin_oe, .timer_capture_in, .timer_channel_zero_pin_block, .irq);
	acc_analog_model model (.analog_enable, .reference_input_select, .bandgap_buffer_enable(bg_buf_en), .pos_mv,
		.neg_mv, .comparator_raw_out);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Trailing edge lets the write land before outputs are looked at
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
		@(posedge pclk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask

	task automatic swing(input logic up);
		pos_mv <= up ? 12'h3e8 : 12'h064;
		repeat (4) @(posedge pclk);
	endtask

	task automatic close_out();
		$display("Counts: %0d mismatches in %0d comparisons", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		close_out();
	end

	initial begin
		{psel, penable, pwrite, debug_active, bg_buf_en} = 5'h0;
		{paddr, pwdata} = 44'h0;
		pstrb = 4'hf;
		pos_mv = 12'h064;
		neg_mv = 12'h1f4;
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdc(12'h000, 32'h0);
		rdc(12'h008, 32'h0);
		wr(12'h000, 32'hff);
		rdc(12'h000, 32'hd7);
		chk1(reference_input_select, 1'b1);
		bg_buf_en <= 1'b1;
		swing(1'b0);
		rdc(12'h000, 32'hff);
		chk1(irq, 1'b0);
		wr(12'h008, 32'h1);
		chk1(irq, 1'b1);
		chk1(comparator_output_pin, 1'b1);
		rdc(12'h008, 32'h1);
		pos_mv <= 12'h3e8;
		debug_active <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			wr(12'h000, 32'ha0 | 32'(m));
			swing(1'b0);
			rdc(12'h000, 32'h80 | 32'(m) | (m != 1 ? 32'h20 : 32'h0));
			wr(12'h000, 32'ha0 | 32'(m));
			swing(1'b1);
			rdc(12'h000, 32'h88 | 32'(m) | (m[0] ? 32'h20 : 32'h0));
		end
		debug_active <= 1'b0;
		wr(12'h000, 32'h83);
		rdc(12'h000, 32'hab);
		wr(12'h000, 32'h93);
		chk1(irq, 1'b1);
		wr(12'h000, 32'hb3);
		chk1(irq, 1'b0);
		swing(1'b0);
		chk1(irq, 1'b1);
		wr(12'h000, 32'h83);
		chk1(irq, 1'b0);
		wr(12'h000, 32'ha7);
		chk1(comparator_output_pin_oe, 1'b1);
		wr(12'h010, 32'h1);
		chk1(timer_channel_zero_pin_block, 1'b1);
		swing(1'b1);
		chk1(timer_capture_in, 1'b1);
		wr(12'h000, 32'ha3);
		chk1(comparator_output_pin_oe, 1'b0);
		wr(12'h010, 32'h0);
		apb(12'h020, 1'b0, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		wr(12'h020, 32'hff);
		rdc(12'h000, 32'h8b);
		// Fall event lands on the same edge as the flag clear
		pos_mv <= 12'h064;
		wr(12'h000, 32'ha3);
		rdc(12'h000, 32'ha3);
		swing(1'b1);
		wr(12'h000, 32'ha3);
		wr(12'h00c, 32'h1);
		rdc(12'h00c, 32'h1);
		wr(12'h000, 32'h93);
		swing(1'b0);
		chk1(irq, 1'b1);
		wr(12'h000, 32'hb3);
		wr(12'h00c, 32'h2);
		chk1(analog_enable, 1'b0);
		swing(1'b1);
		wr(12'h000, 32'h0);
		wr(12'h00c, 32'h0);
		repeat (4) @(posedge pclk);
		rdc(12'h000, 32'hbb);
		wr(12'h00c, 32'h3);
		chk1(analog_enable, 1'b0);
		wr(12'h00c, 32'h0);
		rdc(12'h000, 32'h0);
		wr(12'h008, 32'h2);
		chk1(irq, 1'b1);
		wr(12'h004, 32'h2);
		chk1(irq, 1'b0);
		close_out();
	end
endmodule
